// *** irsc_top.sv ***
// irsc_top: software request register, pending summary register and
// hardware edge-request clear register behind the move-to/move-from port.
// Assumes enables, current mode and trap enables/requests come from the
// enable/mode and trap registers kept elsewhere on the core clock.
// Read data return one cycle after the read strobe; writes land on its edge.
`timescale 1ns/1ps
module irsc_top
    import irsc_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              NRST_I,
    // move-to/move-from register port
    input  wire logic              MTPR_I,
    input  wire logic              MFPR_I,
    input  wire logic [IDX_W-1:0]  IPR_IDX_I,
    input  wire logic [DATA_W-1:0] WR_DATA_I,
    output logic      [DATA_W-1:0] RD_DATA_O,
    output logic                   RD_VALID_O,
    // enable/mode and trap state kept elsewhere
    input  wire logic [DATA_W-1:0] ENABLE_AND_MODE_REG_I,
    input  wire logic [TRAP_N-1:0] TRAP_MODE_ENABLES_I,
    input  wire logic [TRAP_N-1:0] TRAP_MODE_REQUESTS_I,
    // hardware sources and dispatch handshakes
    input  wire logic [EXT_N-1:0]  EXTERNAL_PIN_I,
    input  wire logic              SERIAL_LINE_EVT_I,
    input  wire logic              CORRECTED_READ_ERR_EVT_I,
    input  wire logic [PERF_N-1:0] PERF_COUNTER_EVT_I,
    input  wire logic              DATA_MACHINE_CHECK_EVT_I,
    input  wire logic              NATIVE_RETURN_I,
    input  wire logic              ICACHE_FILL_HIT_I,
    // requests towards exception dispatch
    output logic                   INT_REQUEST_O,
    output logic                   INT_RESIGNAL_O,
    output logic                   DATA_MACHINE_CHECK_O,
    output logic                   FORCE_BAD_FILL_PARITY_O
);

    function automatic logic hit(input logic [IDX_W-1:0] idx,
                                 input logic [IDX_W-1:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    irsc_access_s acc;
    assign acc = '{wr: MTPR_I, rd: MFPR_I,
                   idx: IPR_IDX_I, data: WR_DATA_I};

    // external pins: two-stage synchroniser
    logic [EXT_N-1:0] ext_s1_q;
    logic [EXT_N-1:0] ext_s2_q;
    logic [EXT_N-1:0] ext_prev_q;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ext_s1_q   <= '0;
            ext_s2_q   <= '0;
            ext_prev_q <= '0;
        end else begin
            ext_s1_q   <= EXTERNAL_PIN_I;
            ext_s2_q   <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
        end
    end

    // edge-request latches
    irsc_edge_s edge_set;
    irsc_edge_s edge_clr;
    irsc_edge_s edge_flag;
    logic       clr_wr;

    assign clr_wr   = acc.wr & hit(acc.idx, IDX_EDGE_CLEAR);
    assign edge_set = '{serial: SERIAL_LINE_EVT_I,
                        crd:    CORRECTED_READ_ERR_EVT_I,
                        perf:   PERF_COUNTER_EVT_I,
                        mchk:   DATA_MACHINE_CHECK_EVT_I};
    assign edge_clr = '{serial: clr_wr & acc.data[SERIAL_BIT],
                        crd:    clr_wr & acc.data[CRD_BIT],
                        perf:   {PERF_N{clr_wr}} & acc.data[PERF_LSB +: PERF_N],
                        mchk:   clr_wr & acc.data[MCHK_BIT]};

    // set beats a coincident write-one clear
    irsc_edge_latch #(
        .N (EDGE_N)
    ) u_edge (
        .CLK_I  (CLK_I),
        .NRST_I (NRST_I),
        .SET_I  (edge_set),
        .CLR_I  (edge_clr),
        .FLAG_O (edge_flag)
    );

    // software request register and one-shot parity arm
    logic [SOFT_N-1:0] soft_request_q;
    logic [SOFT_N-1:0] soft_request_d;
    logic              fpar_q;
    logic              fpar_d;

    always_comb begin
        soft_request_d = soft_request_q;
        if (acc.wr && hit(acc.idx, IDX_SOFT_REQ)) begin
            soft_request_d = acc.data[SOFT_LSB +: SOFT_N];
        end
        fpar_d = fpar_q;
        if (ICACHE_FILL_HIT_I) begin
            fpar_d = 1'b0;
        end
        if (clr_wr && acc.data[FPAR_BIT]) begin
            fpar_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            soft_request_q <= SOFT_RESET;
            fpar_q         <= 1'b0;
        end else begin
            soft_request_q <= soft_request_d;
            fpar_q         <= fpar_d;
        end
    end

    // summary assembly
    logic [MODE_W-1:0] cur_mode;
    logic [TRAP_N-1:0] trap_pending;
    logic [DATA_W-1:0] summary;

    assign cur_mode = ENABLE_AND_MODE_REG_I[MODE_LSB +: MODE_W];

    // trap bit m belongs to mode code m, kernel 0 up to user 3
    genvar m;
    generate
        for (m = 0; m < TRAP_N; m++) begin : g_trap
            assign trap_pending[m] = TRAP_MODE_ENABLES_I[m] & TRAP_MODE_REQUESTS_I[m]
                                     & (cur_mode >= MODE_W'(m));
        end
    endgenerate

    always_comb begin
        summary = ZERO_WORD;
        summary[EXT_LSB +: EXT_N]   = ext_s2_q
                                      & ENABLE_AND_MODE_REG_I[EXT_LSB +: EXT_N];
        summary[SERIAL_BIT]         = edge_flag.serial
                                      & ENABLE_AND_MODE_REG_I[SERIAL_BIT];
        summary[CRD_BIT]            = edge_flag.crd
                                      & ENABLE_AND_MODE_REG_I[CRD_BIT];
        summary[PERF_LSB +: PERF_N] = edge_flag.perf
                                      & ENABLE_AND_MODE_REG_I[PERF_LSB +: PERF_N];
        summary[SOFT_LSB +: SOFT_N] = soft_request_q
                                      & ENABLE_AND_MODE_REG_I[SOFT_LSB +: SOFT_N];
        summary[TRAP_U_BIT]         = trap_pending[MODE_USER];
        summary[TRAP_S_BIT]         = trap_pending[MODE_SUPERVISOR];
        summary[TRAP_E_BIT]         = trap_pending[MODE_EXECUTIVE];
        summary[TRAP_K_BIT]         = trap_pending[MODE_KERNEL];
    end

    // read path and collision handling
    logic              ext_rise;
    logic              new_hw_evt;
    logic              sum_rd;
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;
    logic              rd_valid_q;
    logic              rd_valid_d;
    logic              resig_q;
    logic              resig_d;

    // external rising edge seen only after the synchroniser
    assign ext_rise   = |(ext_s2_q & ~ext_prev_q);
    assign new_hw_evt = ext_rise | SERIAL_LINE_EVT_I
                        | CORRECTED_READ_ERR_EVT_I | (|PERF_COUNTER_EVT_I);
    assign sum_rd     = acc.rd & hit(acc.idx, IDX_PENDING);

    always_comb begin
        rd_data_d = ZERO_WORD;
        rd_valid_d = acc.rd;
        if (acc.rd && hit(acc.idx, IDX_SOFT_REQ)) begin
            rd_data_d[SOFT_LSB +: SOFT_N] = soft_request_q;
        end else if (sum_rd && !new_hw_evt) begin
            rd_data_d = summary;
        end
        // collided read returns zeros: rd_data_d stays zero
        resig_d = resig_q;
        if (NATIVE_RETURN_I) begin
            resig_d = 1'b0;
        end
        if (sum_rd && new_hw_evt) begin
            resig_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rd_data_q  <= ZERO_WORD;
            rd_valid_q <= 1'b0;
            resig_q    <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            resig_q    <= resig_d;
        end
    end

    assign RD_DATA_O               = rd_data_q;
    assign RD_VALID_O              = rd_valid_q;
    assign INT_REQUEST_O           = |summary;
    assign INT_RESIGNAL_O          = resig_q & NATIVE_RETURN_I & (|summary);
    assign DATA_MACHINE_CHECK_O    = edge_flag.mchk;
    assign FORCE_BAD_FILL_PARITY_O = fpar_q;

endmodule

// *** irsc_pkg.sv ***
// irsc_pkg: constants, field layouts and carrier types for the interrupt
// request, summary and clear registers. Assumes a 64-bit register datapath.
package irsc_pkg;

    localparam int unsigned DATA_W     = 64;
    localparam int unsigned IDX_W      = 8;
    localparam int unsigned EXT_N      = 6;
    localparam int unsigned PERF_N     = 2;
    localparam int unsigned SOFT_N     = 15;
    localparam int unsigned MODE_W     = 2;
    localparam int unsigned TRAP_N     = 4;

    // register indexes on the move-to/move-from port
    localparam logic [IDX_W-1:0] IDX_SOFT_REQ   = 8'h0C;
    localparam logic [IDX_W-1:0] IDX_PENDING    = 8'h0D;
    localparam logic [IDX_W-1:0] IDX_EDGE_CLEAR = 8'h0E;

    // field positions shared by summary, enables and clear
    localparam int unsigned EXT_LSB    = 33;
    localparam int unsigned SERIAL_BIT = 32;
    localparam int unsigned CRD_BIT    = 31;
    localparam int unsigned PERF_LSB   = 29;
    localparam int unsigned SOFT_LSB   = 14;
    localparam int unsigned MCHK_BIT   = 28;
    localparam int unsigned FPAR_BIT   = 26;
    localparam int unsigned TRAP_U_BIT = 10;
    localparam int unsigned TRAP_S_BIT = 9;
    localparam int unsigned TRAP_E_BIT = 4;
    localparam int unsigned TRAP_K_BIT = 3;
    localparam int unsigned MODE_LSB   = 3;

    localparam logic [SOFT_N-1:0] SOFT_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD  = 64'h0000_0000_0000_0000;

    // processor mode encoding; trap bit index 0 kernel .. 3 user
    typedef enum logic [MODE_W-1:0] {
        MODE_KERNEL     = 2'b00,
        MODE_EXECUTIVE  = 2'b01,
        MODE_SUPERVISOR = 2'b10,
        MODE_USER       = 2'b11
    } irsc_mode_e;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } irsc_access_s;

    typedef struct packed {
        logic              serial;
        logic              crd;
        logic [PERF_N-1:0] perf;
        logic              mchk;
    } irsc_edge_s;

    localparam int unsigned EDGE_N = $bits(irsc_edge_s);

endpackage

// *** irsc_edge_latch.sv ***
// irsc_edge_latch: sticky request flags, set by hardware pulses and cleared
// by write-one pulses. Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
module irsc_edge_latch
    import irsc_pkg::*;
#(
    parameter int unsigned N = EDGE_N
) (
    input  wire logic         CLK_I,
    input  wire logic         NRST_I,
    input  wire logic [N-1:0] SET_I,
    input  wire logic [N-1:0] CLR_I,
    output logic      [N-1:0] FLAG_O
);

    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            // set beats a coincident clear
            always_comb begin
                flag_d[g] = SET_I[g] | (flag_q[g] & ~CLR_I[g]);
            end
        end
    endgenerate

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign FLAG_O = flag_q;

endmodule

// *** irsc_top_assertions.sv ***
// irsc_top_assertions: port-level checks of the request, summary and clear registers.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module irsc_top_chk
    import irsc_pkg::*;
(
    input wire logic              CLK_I,
    input wire logic              NRST_I,
    input wire logic              MTPR_I,
    input wire logic              MFPR_I,
    input wire logic [IDX_W-1:0]  IPR_IDX_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic [DATA_W-1:0] RD_DATA_O,
    input wire logic              RD_VALID_O,
    input wire logic              SERIAL_LINE_EVT_I,
    input wire logic              CORRECTED_READ_ERR_EVT_I,
    input wire logic [PERF_N-1:0] PERF_COUNTER_EVT_I,
    input wire logic              DATA_MACHINE_CHECK_EVT_I,
    input wire logic              NATIVE_RETURN_I,
    input wire logic              INT_REQUEST_O,
    input wire logic              INT_RESIGNAL_O,
    input wire logic              DATA_MACHINE_CHECK_O,
    input wire logic              FORCE_BAD_FILL_PARITY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic clr_wr;
    logic hw_evt;
    assign clr_wr = MTPR_I && IPR_IDX_I == IDX_EDGE_CLEAR;
    assign hw_evt = SERIAL_LINE_EVT_I || CORRECTED_READ_ERR_EVT_I || |PERF_COUNTER_EVT_I;
    chk_read_answer: assert property (MFPR_I |=> RD_VALID_O)
        else $error("read not answered");
    chk_idle_zero: assert property (!MFPR_I |=> !RD_VALID_O && RD_DATA_O == ZERO_WORD)
        else $error("idle read port not zero");
    chk_reserved_zero: assert property (RD_VALID_O |-> RD_DATA_O[63:39] == '0 && RD_DATA_O[13:11] == '0
        && RD_DATA_O[8:5] == '0 && RD_DATA_O[2:0] == '0) else $error("reserved bits set");
    chk_collide_zero: assert property (MFPR_I && IPR_IDX_I == IDX_PENDING && hw_evt |=> RD_DATA_O == ZERO_WORD)
        else $error("colliding summary read not zero");
    chk_clear_unread: assert property (MFPR_I && IPR_IDX_I == IDX_EDGE_CLEAR |=> RD_DATA_O == ZERO_WORD)
        else $error("clear register readable");
    chk_mchk_latch: assert property (DATA_MACHINE_CHECK_EVT_I |=> DATA_MACHINE_CHECK_O)
        else $error("machine check not latched");
    chk_mchk_clear: assert property (clr_wr && WR_DATA_I[MCHK_BIT] && !DATA_MACHINE_CHECK_EVT_I
        |=> !DATA_MACHINE_CHECK_O) else $error("machine check not cleared");
    chk_mchk_cause: assert property ($rose(DATA_MACHINE_CHECK_O) |-> $past(DATA_MACHINE_CHECK_EVT_I))
        else $error("machine check without event");
    chk_parity_arm: assert property (clr_wr && WR_DATA_I[FPAR_BIT] |=> FORCE_BAD_FILL_PARITY_O)
        else $error("parity fault not armed");
    chk_resignal_cause: assert property (INT_RESIGNAL_O |-> NATIVE_RETURN_I && INT_REQUEST_O)
        else $error("resignal without cause");
    cov_collide: cover property (MFPR_I && IPR_IDX_I == IDX_PENDING && hw_evt);
    cov_resignal: cover property (INT_RESIGNAL_O);
    cov_parity: cover property (FORCE_BAD_FILL_PARITY_O ##1 !FORCE_BAD_FILL_PARITY_O);
endmodule

bind irsc_top irsc_top_chk u_chk (
    .CLK_I                    (CLK_I),
    .NRST_I                   (NRST_I),
    .MTPR_I                   (MTPR_I),
    .MFPR_I                   (MFPR_I),
    .IPR_IDX_I                (IPR_IDX_I),
    .WR_DATA_I                (WR_DATA_I),
    .RD_DATA_O                (RD_DATA_O),
    .RD_VALID_O               (RD_VALID_O),
    .SERIAL_LINE_EVT_I        (SERIAL_LINE_EVT_I),
    .CORRECTED_READ_ERR_EVT_I (CORRECTED_READ_ERR_EVT_I),
    .PERF_COUNTER_EVT_I       (PERF_COUNTER_EVT_I),
    .DATA_MACHINE_CHECK_EVT_I (DATA_MACHINE_CHECK_EVT_I),
    .NATIVE_RETURN_I          (NATIVE_RETURN_I),
    .INT_REQUEST_O            (INT_REQUEST_O),
    .INT_RESIGNAL_O           (INT_RESIGNAL_O),
    .DATA_MACHINE_CHECK_O     (DATA_MACHINE_CHECK_O),
    .FORCE_BAD_FILL_PARITY_O  (FORCE_BAD_FILL_PARITY_O)
);

// *** irsc_src_model.sv ***
// irsc_src_model: hardware interrupt sources, pulsed edge requests and pin levels.
// Assumes its tasks are called just after a falling clock edge.
`timescale 1ns/1ps
module irsc_src_model
    import irsc_pkg::*;
(
    input  wire logic             CLK_I,
    output logic      [EXT_N-1:0] EXT_O,
    output irsc_edge_s            EVT_O
);
    initial begin
        EXT_O = '0;
        EVT_O = '0;
    end
    // one-cycle event pulse on the selected sources
    task automatic pulse(input logic [EDGE_N-1:0] m);
        EVT_O = m;
        @(negedge CLK_I);
        EVT_O = '0;
    endtask
    task automatic level(input logic [EXT_N-1:0] v);
        EXT_O = v;
    endtask
endmodule

// *** test_interrupt_request_summary_clear.sv ***
// test_interrupt_request_summary_clear: register-access tests of irsc_top.
// Assumes irsc_src_model drives the event pulses and pins.
`timescale 1ns/1ps
module test_interrupt_request_summary_clear
    import irsc_pkg::*;
;
    localparam logic [DATA_W-1:0] ENA = 64'h0000_007F_FFFF_E000;
    localparam logic [DATA_W-1:0] SL  = 64'h0000_0001_0000_0000;
    logic              CLK_I, NRST_I, mtpr, mfpr, nat, fill, rvalid, ireq, iresig, mchk, fpar;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] wdat, rdat, ier, ex;
    logic [TRAP_N-1:0] ten, trq;
    logic [EXT_N-1:0]  ext;
    irsc_edge_s        ev;
    int                failures = 0, compares = 0, cyc = 0, k;
    irsc_src_model src (.CLK_I(CLK_I), .EXT_O(ext), .EVT_O(ev));
    irsc_top dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .MTPR_I(mtpr), .MFPR_I(mfpr), .IPR_IDX_I(idx),
        .WR_DATA_I(wdat), .RD_DATA_O(rdat), .RD_VALID_O(rvalid), .ENABLE_AND_MODE_REG_I(ier),
        .TRAP_MODE_ENABLES_I(ten), .TRAP_MODE_REQUESTS_I(trq), .EXTERNAL_PIN_I(ext),
        .SERIAL_LINE_EVT_I(ev.serial), .CORRECTED_READ_ERR_EVT_I(ev.crd), .PERF_COUNTER_EVT_I(ev.perf),
        .DATA_MACHINE_CHECK_EVT_I(ev.mchk), .NATIVE_RETURN_I(nat), .ICACHE_FILL_HIT_I(fill),
        .INT_REQUEST_O(ireq), .INT_RESIGNAL_O(iresig), .DATA_MACHINE_CHECK_O(mchk),
        .FORCE_BAD_FILL_PARITY_O(fpar));
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    task automatic report_and_stop;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        mtpr = 1'b1;
        idx = i;
        wdat = d;
        @(negedge CLK_I);
        mtpr = 1'b0;
        @(negedge CLK_I);
    endtask
    task automatic rd(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] exp);
        mfpr = 1'b1;
        idx = i;
        @(negedge CLK_I);
        chk(rvalid ? rdat : {DATA_W{1'bx}}, exp);
        mfpr = 1'b0;
        @(negedge CLK_I);
    endtask
    initial begin
        NRST_I = 1'b0; mtpr = 1'b0; mfpr = 1'b0; nat = 1'b0; fill = 1'b0;
        idx = '0; wdat = '0; ier = '0; ten = '0; trq = '0;
        repeat (4) @(negedge CLK_I);
        NRST_I = 1'b1;
        rd(IDX_SOFT_REQ, ZERO_WORD);
        wr(IDX_SOFT_REQ, '1);
        rd(IDX_SOFT_REQ, 64'h0000_0000_1FFF_C000);
        rd(IDX_PENDING, ZERO_WORD);
        chk(ireq, 64'h0);
        ier = ENA;
        wr(IDX_PENDING, '0);
        rd(IDX_PENDING, 64'h0000_0000_1FFF_C000);
        wr(IDX_SOFT_REQ, 64'h0000_0000_0000_4000);
        ier = ENA & ~64'h0000_0000_0000_4000;
        #1 chk(ireq, 64'h0);
        ier = ENA;
        #1 chk(ireq, 64'h1);
        wr(IDX_SOFT_REQ, '0);
        for (k = 0; k < 4; k++) begin
            src.pulse(5'h10 >> k);
            wr(IDX_EDGE_CLEAR, '0);
            rd(IDX_PENDING, SL >> k);
            wr(IDX_EDGE_CLEAR, SL >> k);
            rd(IDX_PENDING, ZERO_WORD);
        end
        src.level(6'h21);
        repeat (3) @(negedge CLK_I);
        rd(IDX_PENDING, 64'h0000_0042_0000_0000);
        src.level(6'h00);
        repeat (3) @(negedge CLK_I);
        ten = '1;
        trq = '1;
        for (k = 0; k < 4; k++) begin
            ier = ENA | (k << MODE_LSB);
            ex = 64'h8 | (k >= 1 ? 64'h10 : 64'h0) | (k >= 2 ? 64'h200 : 64'h0) | (k >= 3 ? 64'h400 : 64'h0);
            rd(IDX_PENDING, ex);
        end
        ten = 4'hE;
        rd(IDX_PENDING, 64'h0000_0000_0000_0610);
        ten = '0;
        ier = ENA;
        fork
            src.pulse(5'h10);
            rd(IDX_PENDING, ZERO_WORD);
        join
        rd(IDX_PENDING, SL);
        nat = 1'b1;
        #1 chk(iresig, 64'h1);
        @(negedge CLK_I);
        nat = 1'b0;
        wr(IDX_EDGE_CLEAR, SL);
        src.pulse(5'h01);
        chk(mchk, 64'h1);
        wr(IDX_EDGE_CLEAR, 64'h0000_0000_1000_0000);
        chk(mchk, 64'h0);
        wr(IDX_EDGE_CLEAR, 64'h0000_0000_0400_0000);
        chk(fpar, 64'h1);
        fill = 1'b1;
        @(negedge CLK_I);
        fill = 1'b0;
        chk(fpar, 64'h0);
        wr(IDX_SOFT_REQ, '1);
        wr(IDX_EDGE_CLEAR, 64'h0000_0000_0400_0000);
        src.pulse(5'h01);
        chk(ireq, 64'h1);
        NRST_I = 1'b0;
        @(negedge CLK_I);
        NRST_I = 1'b1;
        chk(fpar, 64'h0);
        chk(mchk, 64'h0);
        chk(ireq, 64'h0);
        rd(IDX_SOFT_REQ, ZERO_WORD);
        rd(IDX_EDGE_CLEAR, ZERO_WORD);
        rd(8'h3F, ZERO_WORD);
        report_and_stop();
    end
endmodule
